// ===== rtl/imd_diag_record.sv
// Diagnostic record of a two-channel fast digital input module
`default_nettype none
module imd_diag_record #(
  parameter int TICK_CYCLES = imd_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire imd_pkg::imd_cond_t cond,
  input wire logic diagEnable,
  input wire imd_pkg::imd_rd_req_t rdReq,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic wrEn,
  input wire logic [imd_pkg::IDX_W-1:0] wrIndex,
  input wire logic [7:0] wrData,
  output logic wrAck,
  output logic diagIrq,
  output logic [31:0] usTicker
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int NUM_CH = imd_pkg::NUM_CHANNELS;
  localparam int REC_W = 8;
  localparam int STAMP_BYTES = 4;
  localparam int LANE_W = $clog2(STAMP_BYTES);
  localparam int STAMP_SPAN =
    int'(imd_pkg::OFS_TIMESTAMP_LAST - imd_pkg::OFS_TIMESTAMP) + 1;

  // Refuse settings the record layout cannot serve
  if (TICK_CYCLES < 1)
  begin : gBadTick
    $error("TICK_CYCLES must be at least one");
  end
  if ((NUM_CH < 1) || (NUM_CH > REC_W))
  begin : gBadChannels
    $error("Channel count must fit in the fault byte");
  end
  if (STAMP_SPAN != STAMP_BYTES)
  begin : gBadStamp
    $error("Timestamp window must span four bytes");
  end

  // Microsecond enable divider; a pulse, not a second clock
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] div_nxt;
  logic tick;
  logic [31:0] us_r;
  logic [31:0] us_nxt;

  always_comb
  begin
    tick = (div_r == DIV_W'(TICK_CYCLES - 1));
    if (tick)
    begin
      div_nxt = '0;
      us_nxt = us_r + 32'h0000_0001;
    end
    else
    begin
      div_nxt = div_r + DIV_W'(1);
      us_nxt = us_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      div_r <= '0;
      us_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
      us_r <= us_nxt;
    end
  end

  // Diagnostic state and captured record
  imd_pkg::imd_state_t state_r;
  imd_pkg::imd_state_t state_nxt;
  imd_pkg::imd_cond_t snap_r;
  imd_pkg::imd_cond_t snap_nxt;
  logic [31:0] stamp_r;
  logic [31:0] stamp_nxt;
  logic anyCond;

  always_comb
  begin
    anyCond = |cond;
    state_nxt = state_r;
    snap_nxt = snap_r;
    stamp_nxt = stamp_r;
    case (state_r)
      imd_pkg::IMD_IDLE:
      begin
        if (anyCond)
        begin
          state_nxt = imd_pkg::IMD_ACTIVE;
          snap_nxt = cond;
          stamp_nxt = us_r;
        end
      end
      imd_pkg::IMD_ACTIVE:
      begin
        // Frozen so the host reads one coherent event
        // Newer channel events are dropped meanwhile
        if (!anyCond)
        begin
          state_nxt = imd_pkg::IMD_IDLE;
          snap_nxt = '0;
          stamp_nxt = us_r;
        end
        else
        begin
          snap_nxt = snap_r;
        end
      end
      default:
      begin
        state_nxt = imd_pkg::IMD_IDLE;
        snap_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= imd_pkg::IMD_IDLE;
      snap_r <= '0;
      stamp_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      snap_r <= snap_nxt;
      stamp_r <= stamp_nxt;
    end
  end

  // Channel fault byte, one lane per bit
  wire logic [REC_W-1:0] chFault;

  for (genvar ch = 0; ch < REC_W; ch++)
  begin : gChFault
    if (ch < NUM_CH)
    begin : gUsed
      assign chFault[ch] = snap_r.edgeLost[ch];
    end
    else
    begin : gSpare
      assign chFault[ch] = 1'b0;
    end
  end

  // Timestamp byte lanes, lowest byte first
  wire logic [REC_W-1:0] stampByte [STAMP_BYTES];

  for (genvar b = 0; b < STAMP_BYTES; b++)
  begin : gStampLane
    assign stampByte[b] = stamp_r[REC_W*b +: REC_W];
  end

  // Module flag bytes
  logic [7:0] flagsLo;
  logic [7:0] flagsHi;

  always_comb
  begin
    flagsLo = '0;
    flagsLo[imd_pkg::BIT_CHANNEL_ERROR] = |snap_r.edgeLost;
    flagsHi = '0;
    flagsHi[imd_pkg::BIT_BUF_OVERFLOW] = snap_r.bufOverflow;
    flagsHi[imd_pkg::BIT_PROC_INT_LOST] = snap_r.procIntLost;
  end

  // Byte read port; data holds until the next read
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;
  logic rdValid_r;
  logic rdValid_nxt;
  logic [imd_pkg::IDX_W-1:0] tsOfs;
  logic inStamp;

  always_comb
  begin
    tsOfs = rdReq.index - imd_pkg::OFS_TIMESTAMP;
    inStamp = (rdReq.index >= imd_pkg::OFS_TIMESTAMP)
      && (rdReq.index <= imd_pkg::OFS_TIMESTAMP_LAST);
    rdValid_nxt = rdReq.en;
    rdData_nxt = rdData_r;
    if (rdReq.en && inStamp)
    begin
      rdData_nxt = stampByte[tsOfs[LANE_W-1:0]];
    end
    else if (rdReq.en)
    begin
      case (rdReq.index)
        imd_pkg::OFS_MODULE_FLAGS_LO:
        begin
          rdData_nxt = flagsLo;
        end
        imd_pkg::OFS_MODULE_INFO:
        begin
          rdData_nxt = imd_pkg::MODULE_INFO_VALUE;
        end
        imd_pkg::OFS_MODULE_FLAGS_HI:
        begin
          rdData_nxt = flagsHi;
        end
        imd_pkg::OFS_CHANNEL_KIND:
        begin
          rdData_nxt = {1'b0, imd_pkg::KIND_DIGITAL_INPUT};
        end
        imd_pkg::OFS_BITS_PER_CH:
        begin
          rdData_nxt = imd_pkg::BITS_PER_CH_VALUE;
        end
        imd_pkg::OFS_CHANNEL_COUNT:
        begin
          rdData_nxt = 8'(NUM_CH);
        end
        imd_pkg::OFS_CHANNEL_FAULT:
        begin
          rdData_nxt = chFault;
        end
        // Spare bytes and anything past the record read zero
        default:
        begin
          rdData_nxt = imd_pkg::RESERVED_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdData_r <= '0;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  // Write port; the record is read-only, so writes only ack
  logic wrAck_r;
  logic wrAck_nxt;

  always_comb
  begin
    // Index and data are dropped on purpose
    wrAck_nxt = wrEn;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wrAck_r <= 1'b0;
    end
    else
    begin
      wrAck_r <= wrAck_nxt;
    end
  end

  // Interrupt follows the active state, gated by enable only
  logic irq_r;
  logic irq_nxt;

  always_comb
  begin
    irq_nxt = (state_nxt == imd_pkg::IMD_ACTIVE) && diagEnable;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign wrAck = wrAck_r;
  assign diagIrq = irq_r;
  assign usTicker = us_r;
endmodule
`default_nettype wire

// ===== rtl/imd_pkg.sv
// Constants and types for the input module diagnostic record
`default_nettype none
package imd_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NUM_CHANNELS = 2;
  localparam int IDX_W = 5;

  // Byte positions within the record
  localparam logic [4:0] OFS_MODULE_FLAGS_LO = 5'h00;
  localparam logic [4:0] OFS_MODULE_INFO = 5'h01;
  localparam logic [4:0] OFS_SPARE = 5'h02;
  localparam logic [4:0] OFS_MODULE_FLAGS_HI = 5'h03;
  localparam logic [4:0] OFS_CHANNEL_KIND = 5'h04;
  localparam logic [4:0] OFS_BITS_PER_CH = 5'h05;
  localparam logic [4:0] OFS_CHANNEL_COUNT = 5'h06;
  localparam logic [4:0] OFS_CHANNEL_FAULT = 5'h07;
  localparam logic [4:0] OFS_CH_SPARE_FIRST = 5'h08;
  localparam logic [4:0] OFS_CH_SPARE_LAST = 5'h0f;
  localparam logic [4:0] OFS_TIMESTAMP = 5'h10;
  localparam logic [4:0] OFS_TIMESTAMP_LAST = 5'h13;

  // Field positions and fixed values
  localparam int BIT_CHANNEL_ERROR = 3;
  localparam int BIT_BUF_OVERFLOW = 3;
  localparam int BIT_PROC_INT_LOST = 6;
  localparam logic [6:0] KIND_DIGITAL_INPUT = 7'h70;
  localparam logic [7:0] BITS_PER_CH_VALUE = 8'h00;
  localparam logic [7:0] MODULE_INFO_VALUE = 8'h1f;
  localparam logic [7:0] RESERVED_BYTE = 8'h00;

  typedef struct packed {
    logic procIntLost;
    logic bufOverflow;
    logic [NUM_CHANNELS-1:0] edgeLost;
  } imd_cond_t;

  typedef struct packed {
    logic en;
    logic [IDX_W-1:0] index;
  } imd_rd_req_t;

  typedef enum logic {IMD_IDLE, IMD_ACTIVE} imd_state_t;
endpackage
`default_nettype wire

// ===== verification/imd_coupler.sv
// Coupler model: keeps the last byte answered while rdValid is high
`default_nettype none
module imd_coupler (
  input wire logic clk,
  input wire logic rdValid,
  input wire logic [7:0] rdData,
  output logic [7:0] got
);
  timeunit 1ns / 1ps;
  always_ff @(posedge clk)
    if (rdValid) got <= rdData;
endmodule
`default_nettype wire

// ===== verification/imd_diag_record_asserts.sv
// Port assertions for the record
`default_nettype none
module imd_diag_record_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire imd_pkg::imd_cond_t cond,
  input wire logic diagEnable,
  input wire imd_pkg::imd_rd_req_t rdReq,
  input wire logic [7:0] rdData,
  input wire logic diagIrq,
  input wire logic [31:0] usTicker
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_kd; rdReq == 6'h24 |=> rdData == 8'h70; endproperty
  a_kd: assert property (p_kd) else $error("kind");
  property p_nb; rdReq == 6'h25 |=> rdData == 8'h00; endproperty
  a_nb: assert property (p_nb) else $error("bits");
  property p_nc; rdReq == 6'h26 |=> rdData == 8'h02; endproperty
  a_nc: assert property (p_nc) else $error("count");
  property p_sp; rdReq == 6'h22 |=> rdData == 8'h00; endproperty
  a_sp: assert property (p_sp) else $error("spare");
  property p_tk; usTicker - $past(usTicker) <= 32'h1; endproperty
  a_tk: assert property (p_tk) else $error("tick");
  property p_on; cond != '0 && diagEnable |=> diagIrq; endproperty
  a_on: assert property (p_on) else $error("irq on");
  property p_of; diagIrq && cond == '0 |=> !diagIrq; endproperty
  a_of: assert property (p_of) else $error("irq off");
  property p_up; $rose(diagIrq) |-> $past(cond) != '0; endproperty
  a_up: assert property (p_up) else $error("irq cause");
endmodule
bind imd_diag_record imd_diag_record_asserts chk (.*);
`default_nettype wire

// ===== verification/tb.sv
// Record testbench
`default_nettype none
module tb;
  timeunit 1ns / 1ps;
  logic clk = 1'b0, rst_n = 1'b0;
  imd_pkg::imd_cond_t cond = '0;
  imd_pkg::imd_rd_req_t rdReq = '0;
  logic [7:0] rdData, got;
  logic rdValid, diagIrq, wrAck;
  logic diagEnable = 1'b1, wrEn = 1'b0;
  logic [4:0] wrIndex = '0;
  logic [7:0] wrData = '0;
  logic [31:0] usTicker, ts;
  int mismatches = 0, samples_checked = 0;
  always #20 clk = ~clk;
  imd_diag_record #(.TICK_CYCLES(2)) dut (.*); // Short tick
  imd_coupler host (.*);
  task chk(input logic [31:0] s, e);
    samples_checked++;
    mismatches += int'(s !== e);
    if (s !== e)
      $display("BAD %0t mismatch", $time);
  endtask
  task rd(input logic [4:0] i, logic [7:0] e);
    @(posedge clk);
    rdReq <= {1'b1, i};
    @(posedge clk);
    rdReq.en <= 1'b0;
    @(posedge clk);
    #1 chk(got, e);
  endtask
  task wr(input logic [4:0] i, logic [7:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    wrIndex <= i;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
    #1 chk(wrAck, 1'b1);
  endtask
  task ev(input logic [3:0] v);
    @(posedge clk);
    cond <= v;
    #1 ts = usTicker;
    @(posedge clk);
  endtask
  task print_verdict();
    $display("%0d checks, %0d bad", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(5'h04, 8'h70);
    rd(5'h05, 8'h00);
    rd(5'h06, 8'h02);
    rd(5'h02, 8'h00);
    ts = usTicker;
    repeat (8) @(posedge clk);
    #1 chk(usTicker - ts, 32'h4);
    ev(4'h1);
    #1 chk(diagIrq, 1'b1);
    rd(5'h07, 8'h01);
    rd(5'h00, 8'h08);
    for (int i = 0; i < 4; i++)
      rd(5'h10 + 5'(i), ts[8*i+:8]);
    ev(4'hf);
    rd(5'h07, 8'h01);
    ev(4'h0);
    #1 chk(diagIrq, 1'b0);
    ev(4'he);
    rd(5'h03, 8'h48);
    rd(5'h07, 8'h02);
    wr(5'h04, 8'hff);
    wr(5'h07, 8'h00);
    rd(5'h04, 8'h70);
    rd(5'h07, 8'h02);
    ev(4'h0);
    diagEnable <= 1'b0;
    ev(4'h2);
    #1 chk(diagIrq, 1'b0);
    rd(5'h07, 8'h02);
    diagEnable <= 1'b1;
    @(posedge clk);
    #1 chk(diagIrq, 1'b1);
    ev(4'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk(usTicker, 32'h0);
    rd(5'h07, 8'h00);
    $display("tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
